// [inc/pmon_i2c_pkg.sv]
package pmon_i2c_pkg;

   localparam int          BYTE_BITS   = 8;
   localparam int          ADDR_BITS   = 7;
   localparam logic [4:0]  ADDR_BASE   = 5'h0B;
   localparam logic [1:0]  STRAP_RST   = 2'h0;
   // Strap is taken only once both sync stages hold the pin, not their reset value
   localparam logic [1:0]  STRAP_TAKE  = 2'h2;
   localparam logic [3:0]  LAST_BIT    = 4'h7;
   localparam logic [3:0]  STUB_BITS   = 4'h1;
   localparam int          CMD_EXT_BIT = 7;

   // Bus clock limit against the core clock; a bit lasts many core cycles
   localparam int          CLK_FREQ_HZ = 200_000_000;
   localparam int          SCL_MAX_HZ  = 400_000;
   localparam int          SCL_MIN_CYC = CLK_FREQ_HZ / SCL_MAX_HZ;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_ACK     = 3'b010,
      ST_WR_BYTE = 3'b011,
      ST_RD_BYTE = 3'b100,
      ST_RD_ACK  = 3'b101,
      ST_IGNORE  = 3'b110
   } tgt_state_e;

endpackage

// [rtl/i2c_line_sync.sv]
module i2c_line_sync
   import pmon_i2c_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic clk_en_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o,
   output logic      scl_rise_o,
   output logic      scl_fall_o,
   output logic      start_o,
   output logic      stop_o
);

   logic [2:0] scl_reg;
   logic [2:0] sda_reg;
   logic [2:0] scl_next;
   logic [2:0] sda_next;

   // Two stages before any logic looks at the pins; third stage is history
   always_comb begin
      scl_next = scl_reg;
      sda_next = sda_reg;
      if (clk_en_i) begin
         scl_next = {scl_reg[1:0], scl_i};
         sda_next = {sda_reg[1:0], sda_i};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         scl_reg <= 3'h7;
         sda_reg <= 3'h7;
      end else begin
         scl_reg <= scl_next;
         sda_reg <= sda_next;
      end
   end

   assign scl_o      = scl_reg[1];
   assign sda_o      = sda_reg[1];
   assign scl_rise_o = scl_reg[1] & ~scl_reg[2];
   assign scl_fall_o = ~scl_reg[1] & scl_reg[2];
   // Clock must be high on both samples so a skewed edge is not taken
   assign start_o    = scl_reg[1] & scl_reg[2] & sda_reg[2] & ~sda_reg[1];
   assign stop_o     = scl_reg[1] & scl_reg[2] & ~sda_reg[2] & sda_reg[1];

   property p_start_stop_excl;
      @(posedge ref_clk_i) disable iff (srst_i)
      !(start_o && stop_o);
   endproperty
   a_start_stop_excl: assert property (p_start_stop_excl) else $error("start and stop together");

   property p_start_needs_high;
      @(posedge ref_clk_i) disable iff (srst_i)
      start_o |-> $past(scl_reg[1]) && !scl_fall_o;
   endproperty
   a_start_needs_high: assert property (p_start_needs_high) else $error("start without clock high");

endmodule

// [rtl/pmon_i2c_target.sv]
module pmon_i2c_target
   import pmon_i2c_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic        clk_en_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o,
   input  wire logic [1:0]  addr_strap_i,
   input  wire logic        rd_ready_i,
   input  wire logic [7:0]  rd_data_i,
   output logic             rd_req_o,
   output logic             cmd_valid_o,
   output logic [7:0]       cmd_byte_o,
   output logic             cmd_ext_o,
   output logic             wr_valid_o,
   output logic [7:0]       wr_data_o,
   output logic             quick_o,
   output logic             busy_o,
   output logic [6:0]       own_addr_o
);

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_s;
   logic stop_s;

   i2c_line_sync u_sync (
      .ref_clk_i  (ref_clk_i),
      .srst_i     (srst_i),
      .clk_en_i   (clk_en_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .scl_o      (scl_s),
      .sda_o      (sda_s),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .start_o    (start_s),
      .stop_o     (stop_s)
   );

   // Strap capture: synchronised, then frozen once after reset
   logic [1:0] strap_s1_reg;
   logic [1:0] strap_s2_reg;
   logic [1:0] strap_reg;
   logic [1:0] strap_cnt_reg;
   logic [1:0] strap_s1_next;
   logic [1:0] strap_s2_next;
   logic [1:0] strap_next;
   logic [1:0] strap_cnt_next;
   logic [6:0] own_addr;

   always_comb begin
      strap_s1_next   = strap_s1_reg;
      strap_s2_next   = strap_s2_reg;
      strap_next      = strap_reg;
      strap_cnt_next  = strap_cnt_reg;
      if (clk_en_i) begin
         strap_s1_next = addr_strap_i;
         strap_s2_next = strap_s1_reg;
         // Later strap changes are ignored: the address is a power-up choice
         if (strap_cnt_reg <= STRAP_TAKE) begin
            strap_cnt_next = strap_cnt_reg + 2'h1;
         end
         if (strap_cnt_reg == STRAP_TAKE) begin
            strap_next = strap_s2_reg;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         strap_s1_reg   <= STRAP_RST;
         strap_s2_reg   <= STRAP_RST;
         strap_reg      <= STRAP_RST;
         strap_cnt_reg  <= 2'h0;
      end else begin
         strap_s1_reg   <= strap_s1_next;
         strap_s2_reg   <= strap_s2_next;
         strap_reg      <= strap_next;
         strap_cnt_reg  <= strap_cnt_next;
      end
   end

   assign own_addr = {ADDR_BASE, strap_reg};

   tgt_state_e state_reg;
   tgt_state_e state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] sh_reg;
   logic [7:0] sh_next;
   logic       rw_reg;
   logic       rw_next;
   logic       first_reg;
   logic       first_next;
   logic       drive_reg;
   logic       drive_next;
   logic       ack_on_reg;
   logic       ack_on_next;
   logic       cmd_valid_reg;
   logic       cmd_valid_next;
   logic [7:0] cmd_byte_reg;
   logic [7:0] cmd_byte_next;
   logic       cmd_ext_reg;
   logic       cmd_ext_next;
   logic       wr_valid_reg;
   logic       wr_valid_next;
   logic [7:0] wr_data_reg;
   logic [7:0] wr_data_next;
   logic       quick_reg;
   logic       quick_next;
   logic       rd_req_reg;
   logic       rd_req_next;
   logic [7:0] in_byte;

   assign in_byte = {sh_reg[6:0], sda_s};

   always_comb begin
      state_next     = state_reg;
      cnt_next       = cnt_reg;
      sh_next        = sh_reg;
      rw_next        = rw_reg;
      first_next     = first_reg;
      drive_next     = drive_reg;
      ack_on_next    = ack_on_reg;
      cmd_valid_next = cmd_valid_reg & ~clk_en_i;
      cmd_byte_next  = cmd_byte_reg;
      cmd_ext_next   = cmd_ext_reg;
      wr_valid_next  = wr_valid_reg & ~clk_en_i;
      wr_data_next   = wr_data_reg;
      quick_next     = quick_reg & ~clk_en_i;
      rd_req_next    = rd_req_reg & ~clk_en_i;
      if (clk_en_i && stop_s) begin
         // A stop during the first bit after the address ack is a presence check
         quick_next  = (state_reg == ST_WR_BYTE) && first_reg && (cnt_reg <= STUB_BITS);
         state_next  = ST_IDLE;
         drive_next  = 1'b0;
         ack_on_next = 1'b0;
      end else if (clk_en_i && start_s) begin
         // Repeated start is taken in any state
         state_next  = ST_ADDR;
         cnt_next    = 4'h0;
         drive_next  = 1'b0;
         ack_on_next = 1'b0;
      end else if (clk_en_i) begin
         unique case (state_reg)
            ST_IDLE, ST_IGNORE: begin
               drive_next = 1'b0;
            end
            ST_ADDR, ST_WR_BYTE: begin
               if (scl_rise) begin
                  sh_next  = in_byte;
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == LAST_BIT) begin
                     cnt_next = 4'h0;
                     if (state_reg == ST_ADDR) begin
                        rw_next    = sda_s;
                        first_next = 1'b1;
                        // A read is refused until results are ready
                        if (sh_reg[6:0] == own_addr && (!sda_s || rd_ready_i)) begin
                           state_next = ST_ACK;
                        end else begin
                           state_next = ST_IGNORE;
                        end
                     end else begin
                        state_next = ST_ACK;
                        first_next = 1'b0;
                        if (first_reg) begin
                           cmd_valid_next = 1'b1;
                           cmd_byte_next  = in_byte;
                           cmd_ext_next   = in_byte[CMD_EXT_BIT];
                        end else begin
                           wr_valid_next = 1'b1;
                           wr_data_next  = in_byte;
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (!ack_on_reg) begin
                     ack_on_next = 1'b1;
                     drive_next  = 1'b1;
                  end else begin
                     ack_on_next = 1'b0;
                     drive_next  = 1'b0;
                     if (rw_reg) begin
                        state_next  = ST_RD_BYTE;
                        sh_next     = rd_data_i;
                        rd_req_next = 1'b1;
                        drive_next  = ~rd_data_i[7];
                     end else begin
                        state_next = ST_WR_BYTE;
                     end
                  end
               end
            end
            ST_RD_BYTE: begin
               // The line only carries our data here, so nothing is sampled
               if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == LAST_BIT) begin
                     cnt_next   = 4'h0;
                     state_next = ST_RD_ACK;
                  end
               end else if (scl_fall) begin
                  sh_next    = {sh_reg[6:0], 1'b0};
                  drive_next = ~sh_reg[6];
               end
            end
            ST_RD_ACK: begin
               if (scl_fall) begin
                  drive_next = 1'b0;
                  if (ack_on_reg) begin
                     ack_on_next = 1'b0;
                     state_next  = ST_RD_BYTE;
                     sh_next     = rd_data_i;
                     rd_req_next = 1'b1;
                     drive_next  = ~rd_data_i[7];
                  end
               end else if (scl_rise) begin
                  if (sda_s) begin
                     state_next = ST_IGNORE;
                  end else begin
                     ack_on_next = 1'b1;
                  end
               end
            end
            default: begin
               state_next = ST_IDLE;
               drive_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= 4'h0;
         sh_reg        <= 8'h00;
         rw_reg        <= 1'b0;
         first_reg     <= 1'b0;
         drive_reg     <= 1'b0;
         ack_on_reg    <= 1'b0;
         cmd_valid_reg <= 1'b0;
         cmd_byte_reg  <= 8'h00;
         cmd_ext_reg   <= 1'b0;
         wr_valid_reg  <= 1'b0;
         wr_data_reg   <= 8'h00;
         quick_reg     <= 1'b0;
         rd_req_reg    <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cnt_reg       <= cnt_next;
         sh_reg        <= sh_next;
         rw_reg        <= rw_next;
         first_reg     <= first_next;
         drive_reg     <= drive_next;
         ack_on_reg    <= ack_on_next;
         cmd_valid_reg <= cmd_valid_next;
         cmd_byte_reg  <= cmd_byte_next;
         cmd_ext_reg   <= cmd_ext_next;
         wr_valid_reg  <= wr_valid_next;
         wr_data_reg   <= wr_data_next;
         quick_reg     <= quick_next;
         rd_req_reg    <= rd_req_next;
      end
   end

   // Open drain: the pad value is always low, only the enable moves
   assign sda_o       = 1'b0;
   assign sda_oe_n_o  = ~drive_reg;
   assign rd_req_o    = rd_req_reg;
   assign cmd_valid_o = cmd_valid_reg;
   assign cmd_byte_o  = cmd_byte_reg;
   assign cmd_ext_o   = cmd_ext_reg;
   assign wr_valid_o  = wr_valid_reg;
   assign wr_data_o   = wr_data_reg;
   assign quick_o     = quick_reg;
   assign busy_o      = (state_reg != ST_IDLE);
   assign own_addr_o  = own_addr;

   property p_ack_hold;
      @(posedge ref_clk_i) disable iff (srst_i)
      (state_reg == ST_ACK) && ack_on_reg && scl_s |-> !sda_oe_n_o;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack not held in ninth clock");

   property p_silent;
      @(posedge ref_clk_i) disable iff (srst_i)
      (state_reg == ST_IGNORE) || (state_reg == ST_IDLE) |-> sda_oe_n_o;
   endproperty
   a_silent: assert property (p_silent) else $error("line driven while not addressed");

   property p_rd_nack_free;
      @(posedge ref_clk_i) disable iff (srst_i)
      (state_reg == ST_RD_ACK) && scl_rise |-> sda_oe_n_o;
   endproperty
   a_rd_nack_free: assert property (p_rd_nack_free) else $error("line driven in master ack bit");

   property p_start_addr;
      @(posedge ref_clk_i) disable iff (srst_i)
      start_s && clk_en_i |=> (state_reg == ST_ADDR) && (cnt_reg == 4'h0) && sda_oe_n_o;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start not followed by address phase");

   property p_stop_idle;
      @(posedge ref_clk_i) disable iff (srst_i)
      stop_s && clk_en_i |=> (state_reg == ST_IDLE) && !busy_o;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not end frame");

   property p_quick;
      @(posedge ref_clk_i) disable iff (srst_i)
      quick_o |-> $past(state_reg) == ST_WR_BYTE && state_reg == ST_IDLE;
   endproperty
   a_quick: assert property (p_quick) else $error("quick command outside write phase");

   property p_cmd_first;
      @(posedge ref_clk_i) disable iff (srst_i)
      cmd_valid_o |-> !first_reg && (state_reg == ST_ACK) && (cmd_ext_o == cmd_byte_o[CMD_EXT_BIT]);
   endproperty
   a_cmd_first: assert property (p_cmd_first) else $error("command byte misplaced");

   property p_addr_match;
      @(posedge ref_clk_i) disable iff (srst_i)
      $past(state_reg) == ST_ADDR && state_reg == ST_ACK |-> $past(sh_reg[6:0]) == own_addr;
   endproperty
   a_addr_match: assert property (p_addr_match) else $error("acked a foreign address");
endmodule

// [test/i2c_master_model.sv]
module i2c_master_model (
   input  wire logic ref_clk_i,
   input  wire logic sda_line_i,
   output logic      scl_o,
   output logic      sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Short phases keep runs brief; the bench raises this to the 400 kHz figure once
   int half = 20;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // Also serves as repeated start from mid-frame
   task automatic start();
      tick(1);
      sda_o <= 1'b1;
      tick(half);
      scl_o <= 1'b1;
      tick(half);
      sda_o <= 1'b0;
      tick(half);
      scl_o <= 1'b0;
   endtask

   task automatic stop();
      tick(1);
      sda_o <= 1'b0;
      tick(half);
      scl_o <= 1'b1;
      tick(half);
      sda_o <= 1'b1;
      tick(half);
   endtask

   // Data moves only with the clock low; line sampled mid-high
   task automatic send_bit(input logic b, output logic got);
      tick(1);
      sda_o <= b;
      tick(half);
      scl_o <= 1'b1;
      tick(half / 2);
      got = sda_line_i;
      tick(half / 2);
      scl_o <= 1'b0;
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) send_bit(d[i], g);
      send_bit(1'b1, ack);
   endtask

   task automatic read_byte(input logic nack, output logic [7:0] d, output logic g);
      for (int i = 7; i >= 0; i--) send_bit(1'b1, d[i]);
      send_bit(nack, g);
   endtask
endmodule

// [test/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmon_i2c_pkg::*;

   typedef struct packed {logic [1:0] kind; logic [8:0] val;} note_s;

   logic       ref_clk_i, srst_i, clk_en, scl, m_sda, sda_line, dev_sda, sda_oe_n;
   logic       rd_ready, rd_req, cmd_valid, cmd_ext, wr_valid, quick, busy, ack, g;
   logic [1:0] strap;
   logic [7:0] rd_data, cmd_byte, wr_data, d, c;
   logic [6:0] own_addr, a;
   logic [31:0] lfsr_reg = 32'h1D51291E;
   int         n_mismatch = 0;
   int         compares = 0;
   note_s      notes[$];
   logic [7:0] rd_exp[$];

   // Open drain with pull-up: released means high
   assign sda_line = m_sda & (sda_oe_n | dev_sda);

   i2c_master_model i_master (.ref_clk_i(ref_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(m_sda));

   pmon_i2c_target i_dut (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en), .scl_i(scl), .sda_i(sda_line),
      .sda_o(dev_sda), .sda_oe_n_o(sda_oe_n), .addr_strap_i(strap), .rd_ready_i(rd_ready),
      .rd_data_i(rd_data), .rd_req_o(rd_req), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
      .cmd_ext_o(cmd_ext), .wr_valid_o(wr_valid), .wr_data_o(wr_data), .quick_o(quick),
      .busy_o(busy), .own_addr_o(own_addr)
   );

   function automatic logic [7:0] next_rand();
      lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
      return lfsr_reg[7:0];
   endfunction

   task automatic check(input string name, input logic [10:0] exp, input logic [10:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] s);
      @(posedge ref_clk_i);
      srst_i <= 1'b1;
      strap <= s;
      repeat (5) @(posedge ref_clk_i);
      check("reset release", 11'h001, {10'h0, sda_oe_n});
      check("reset busy", 11'h000, {10'h0, busy});
      srst_i <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
   endtask

   // Driver of the read source notes every byte the target loads; the byte keeps moving until ready
   always @(posedge ref_clk_i) begin
      if (rd_req === 1'b1) begin
         rd_exp.push_back(rd_data);
         rd_data <= next_rand();
      end else if (rd_ready !== 1'b1) begin
         rd_data <= next_rand();
      end
   end

   always @(negedge ref_clk_i) begin
      if (sda_oe_n !== 1'b1) check("pad drive", 11'h000, {10'h0, dev_sda});
      if ((cmd_valid | wr_valid | quick) !== 1'b0) begin
         if (notes.size() == 0) check("pulse", 11'h7FF, {2'd2, 9'h0});
         else if (cmd_valid === 1'b1) check("pulse", notes.pop_front(), {2'd0, cmd_ext, cmd_byte});
         else if (wr_valid === 1'b1) check("pulse", notes.pop_front(), {2'd1, 1'b0, wr_data});
         else check("pulse", notes.pop_front(), {2'd2, 9'h0});
      end
   end

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   initial begin
      srst_i = 1'b1;
      clk_en = 1'b1;
      strap = 2'h0;
      rd_ready = 1'b0;
      for (int s = 0; s < 4; s++) begin
         do_reset(s[1:0]);
         a = {ADDR_BASE, s[1:0]};
         check("own address", {4'h0, a}, {4'h0, own_addr});
         i_master.start();
         i_master.write_byte({a ^ 7'h01, 1'b0}, ack);
         check("foreign ack", 11'h001, {10'h0, ack});
         i_master.write_byte(next_rand(), ack);
         check("foreign data ack", 11'h001, {10'h0, ack});
         i_master.stop();
         notes.push_back({2'd2, 9'h0});
         i_master.start();
         i_master.write_byte({a, 1'b0}, ack);
         check("own ack", 11'h000, {10'h0, ack});
         i_master.stop();
      end
      // Normal and extended command, then back-to-back data bytes
      for (int k = 0; k < 2; k++) begin
         if (k == 1) i_master.half = SCL_MIN_CYC / 2;
         c = next_rand();
         c[7] = k[0];
         notes.push_back({2'd0, c[7], c});
         i_master.start();
         i_master.write_byte({a, 1'b0}, ack);
         check("write addr ack", 11'h000, {10'h0, ack});
         i_master.write_byte(c, ack);
         check("cmd ack", 11'h000, {10'h0, ack});
         repeat (3) begin
            d = next_rand();
            notes.push_back({2'd1, 1'b0, d});
            i_master.write_byte(d, ack);
            check("data ack", 11'h000, {10'h0, ack});
         end
         i_master.stop();
         i_master.half = 20;
      end
      // Stop in mid-byte drops the partial byte
      notes.push_back({2'd0, 1'b0, 8'h05});
      i_master.start();
      i_master.write_byte({a, 1'b0}, ack);
      i_master.write_byte(8'h05, ack);
      // A short freeze while the clock line is high must not lose or add a bit
      fork
         begin
            repeat (30) @(posedge ref_clk_i);
            clk_en <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
            clk_en <= 1'b1;
         end
      join_none
      repeat (4) i_master.send_bit(1'b1, g);
      i_master.stop();
      check("busy after stop", 11'h000, {10'h0, busy});
      // Read refused while results are not ready
      i_master.start();
      i_master.write_byte({a, 1'b1}, ack);
      check("not ready read ack", 11'h001, {10'h0, ack});
      i_master.stop();
      @(posedge ref_clk_i);
      rd_ready <= 1'b1;
      // Command write, repeated start, two-byte read ending in a not-acknowledge
      notes.push_back({2'd0, 1'b0, 8'h02});
      i_master.start();
      i_master.write_byte({a, 1'b0}, ack);
      i_master.write_byte(8'h02, ack);
      i_master.start();
      i_master.write_byte({a, 1'b1}, ack);
      check("read addr ack", 11'h000, {10'h0, ack});
      for (int k = 0; k < 2; k++) begin
         i_master.read_byte(k[0], d, g);
         check("read byte", {3'h0, rd_exp.pop_front()}, {3'h0, d});
         if (k == 1) check("nack released", 11'h001, {10'h0, g});
      end
      i_master.stop();
      for (int w = 0; w < 50 && notes.size() > 0; w++) @(posedge ref_clk_i);
      check("notes left", 11'h000, 11'(notes.size()));
      check("reads left", 11'h000, 11'(rd_exp.size()));
      print_verdict();
   end
endmodule
